// ---- src/buck_setpoint_pkg.sv ----
// Constants for the buck regulator set-point register bank.
// Assumes an I2C slave elsewhere delivers decoded register reads and writes.
package buck_setpoint_pkg;
    localparam logic [7:0] ADDR_NORMAL     = 8'h35;
    localparam logic [7:0] ADDR_STANDBY    = 8'h36;
    localparam logic [7:0] ADDR_SLEEP      = 8'h37;
    localparam int         CODE_MSB        = 5;
    localparam int         RANGE_BIT       = 6;
    localparam logic [5:0] CODE_RESET      = 6'h00;
    localparam logic       RANGE_RESET     = 1'b0;
    localparam logic [6:0] MAX_VALID_CODE  = 7'h72;
    localparam int         LOW_BASE_MV     = 400;
    localparam int         LOW_STEP_MV     = 25;
    localparam int         HIGH_BASE_MV    = 800;
    localparam int         HIGH_STEP_MV    = 50;

    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_SLEEP   = 2'b10
    } op_mode_t;
endpackage : buck_setpoint_pkg

// ---- src/buck_setpoint_registers.sv ----
// Set-point register bank for buck regulator two: three mode registers and voltage decode.
// Assumes register accesses arrive already decoded from the I2C slave on clk.
//
// What this block does
// - The range bit of the normal register is read-only and comes only from default or fuse.
// - With range 0 the code maps to 0.400 V plus 25 mV per step up to 1.975 V.
// - With range 1 the code maps to 0.800 V plus 50 mV per step.
// - Combined codes above 1110010 (3.300 V) are reserved and must not be written; the block still stores such a code and raises reserved_write.
// - Three independent six-bit codes exist and the one for the current mode is applied.
// - At initialisation the normal range bit is copied into standby and sleep range bits.
// - The registers sit at 0x35, 0x36 and 0x37, with bit 7 unused.
`timescale 1ns/1ns
module buck_setpoint_registers (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Fuse configuration
    input  wire logic       fuse_valid,
    input  wire logic       fuse_range,
    // Register access
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_hit,
    output logic            reserved_write,
    // Operating mode
    input  wire logic [1:0] op_mode,
    // Applied set point
    output logic      [6:0] applied_code,
    output logic     [11:0] applied_mv
);
    logic [5:0]  normal_code_q;
    logic [5:0]  standby_code_q;
    logic [5:0]  sleep_code_q;
    logic        range_q;
    logic        standby_range_q;
    logic        sleep_range_q;
    logic        init_done_q;
    logic [6:0]  sel_code_d;
    logic [11:0] mv_d;

    function automatic logic [1:0] decode_addr(input logic [7:0] a);
        if (a == buck_setpoint_pkg::ADDR_NORMAL) begin
            return 2'h1;
        end else if (a == buck_setpoint_pkg::ADDR_STANDBY) begin
            return 2'h2;
        end else if (a == buck_setpoint_pkg::ADDR_SLEEP) begin
            return 2'h3;
        end else begin
            return 2'h0;
        end
    endfunction : decode_addr

    always_ff @(posedge clk) begin
        if (reset) begin
            range_q     <= buck_setpoint_pkg::RANGE_RESET;
            init_done_q <= 1'b0;
        end else if (!init_done_q) begin
            range_q     <= fuse_valid ? fuse_range : buck_setpoint_pkg::RANGE_RESET;
            init_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            standby_range_q <= buck_setpoint_pkg::RANGE_RESET;
            sleep_range_q   <= buck_setpoint_pkg::RANGE_RESET;
        end else if (!init_done_q) begin
            standby_range_q <= fuse_valid ? fuse_range : buck_setpoint_pkg::RANGE_RESET;
            sleep_range_q   <= fuse_valid ? fuse_range : buck_setpoint_pkg::RANGE_RESET;
        end
    end

    // independent codes; range bits not written
    always_ff @(posedge clk) begin
        if (reset) begin
            normal_code_q  <= buck_setpoint_pkg::CODE_RESET;
            standby_code_q <= buck_setpoint_pkg::CODE_RESET;
            sleep_code_q   <= buck_setpoint_pkg::CODE_RESET;
        end else if (reg_wr) begin
            case (decode_addr(reg_addr))
                2'h1: normal_code_q  <= reg_wdata[buck_setpoint_pkg::CODE_MSB:0];
                2'h2: standby_code_q <= reg_wdata[buck_setpoint_pkg::CODE_MSB:0];
                2'h3: sleep_code_q   <= reg_wdata[buck_setpoint_pkg::CODE_MSB:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (decode_addr(reg_addr))
                2'h1: reg_rdata <= {1'b0, range_q, normal_code_q};
                2'h2: reg_rdata <= {1'b0, standby_range_q, standby_code_q};
                2'h3: reg_rdata <= {1'b0, sleep_range_q, sleep_code_q};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    assign reg_hit = (decode_addr(reg_addr) != 2'h0);

    always_ff @(posedge clk) begin
        if (reset) begin
            reserved_write <= 1'b0;
        end else begin
            reserved_write <= reg_wr && reg_hit && range_q &&
                ({1'b1, reg_wdata[5:0]} > buck_setpoint_pkg::MAX_VALID_CODE);
        end
    end

    always_comb begin
        case (op_mode)
            buck_setpoint_pkg::MODE_STANDBY: sel_code_d = {standby_range_q, standby_code_q};
            buck_setpoint_pkg::MODE_SLEEP:   sel_code_d = {sleep_range_q, sleep_code_q};
            default:                         sel_code_d = {range_q, normal_code_q};
        endcase
    end

    always_comb begin
        if (sel_code_d[buck_setpoint_pkg::RANGE_BIT]) begin
            mv_d = 12'(buck_setpoint_pkg::HIGH_BASE_MV
                       + buck_setpoint_pkg::HIGH_STEP_MV * int'(sel_code_d[5:0]));
        end else begin
            mv_d = 12'(buck_setpoint_pkg::LOW_BASE_MV
                       + buck_setpoint_pkg::LOW_STEP_MV * int'(sel_code_d[5:0]));
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            applied_code <= 7'h00;
            applied_mv   <= 12'h190;
        end else begin
            applied_code <= sel_code_d;
            applied_mv   <= mv_d;
        end
    end

    // Assertions
    property p_range_stable;
        @(posedge clk) disable iff (reset)
        init_done_q && $past(init_done_q) |-> $stable(range_q);
    endproperty
    a_range_stable: assert property (p_range_stable) else $error("range bit changed");

    property p_copy;
        @(posedge clk) disable iff (reset)
        init_done_q |-> (standby_range_q == range_q) && (sleep_range_q == range_q);
    endproperty
    a_copy: assert property (p_copy) else $error("range bits differ");

    property p_low_mv;
        @(posedge clk) disable iff (reset)
        !sel_code_d[6] |=> applied_mv == 12'(400 + 25 * int'($past(sel_code_d[5:0])));
    endproperty
    a_low_mv: assert property (p_low_mv) else $error("low range decode wrong");

    property p_high_mv;
        @(posedge clk) disable iff (reset)
        sel_code_d[6] |=> applied_mv == 12'(800 + 50 * int'($past(sel_code_d[5:0])));
    endproperty
    a_high_mv: assert property (p_high_mv) else $error("high range decode wrong");

    property p_write_norm;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_addr == 8'h35 |=> normal_code_q == $past(reg_wdata[5:0]);
    endproperty
    a_write_norm: assert property (p_write_norm) else $error("normal write lost");

    property p_readback;
        @(posedge clk) disable iff (reset)
        reg_rd && reg_addr == 8'h36 ##0 !reg_wr
            |=> reg_rdata == {1'b0, standby_range_q, standby_code_q};
    endproperty
    a_readback: assert property (p_readback) else $error("standby read wrong");

    property p_range_wr;
        @(posedge clk) disable iff (reset)
        init_done_q && reg_wr |=> sleep_range_q == $past(sleep_range_q);
    endproperty
    a_range_wr: assert property (p_range_wr) else $error("range bit written");

    property p_reserved;
        @(posedge clk) disable iff (reset)
        reg_wr && reg_hit && range_q && reg_wdata[5:0] > 6'h32 |=> reserved_write;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved not flagged");

    property p_no_reserved;
        @(posedge clk) disable iff (reset)
        reg_wr && !(reg_hit && range_q && reg_wdata[5:0] > 6'h32) |=> !reserved_write;
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("valid code flagged");

    property p_fuse_init;
        @(posedge clk) disable iff (reset)
        !init_done_q |=> range_q == $past(fuse_valid && fuse_range);
    endproperty
    a_fuse_init: assert property (p_fuse_init) else $error("range not from fuse");

    property p_unmapped;
        @(posedge clk) disable iff (reset)
        reg_rd && !reg_hit |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_mode_apply;
        @(posedge clk) disable iff (reset)
        op_mode == buck_setpoint_pkg::MODE_STANDBY
            |=> applied_code == $past({standby_range_q, standby_code_q});
    endproperty
    a_mode_apply: assert property (p_mode_apply) else $error("standby code not applied");

    c_sleep: cover property (@(posedge clk) op_mode == 2'b10 ##1 applied_code == sel_code_d);
    c_high: cover property (@(posedge clk) applied_code[6]);
    c_resv: cover property (@(posedge clk) reserved_write);
    c_unmapped: cover property (@(posedge clk) reg_rd && !reg_hit);
endmodule : buck_setpoint_registers

// ---- bench/reg_host_model.sv ----
// Host model issuing decoded register reads and writes.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ns
module reg_host_model (
    // Clock
    input  wire logic       clk,
    // Register access
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reserved_write
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d, input int gap,
                         output logic f);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #2;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #2;
        reg_wr = 1'b0;
        reg_wdata = ~d;
        f = reserved_write;
    endtask : write
    task automatic read(input logic [7:0] a, input int gap, output logic [7:0] d);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #2;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #2;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : read
endmodule : reg_host_model

// ---- bench/buck_setpoint_registers_tb.sv ----
// Bench for the set-point register bank.
// Assumes 25 MHz clock and synchronous active-high reset.
`timescale 1ns/1ns
module buck_setpoint_registers_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        fuse_valid = 1'b0;
    logic        fuse_range = 1'b0;
    logic  [1:0] op_mode = 2'h0;
    logic        reg_wr, reg_rd, reg_hit, reserved_write, rng, f;
    logic  [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic  [6:0] applied_code;
    logic [11:0] applied_mv;
    logic  [5:0] code_e [3];
    logic [31:0] seed = 32'h0000001A;
    int          err_total = 0;
    int          total_checks = 0;
    always #20 clk = ~clk;
    reg_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reserved_write(reserved_write));
    buck_setpoint_registers dut (.clk(clk), .reset(reset), .fuse_valid(fuse_valid),
        .fuse_range(fuse_range), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .reserved_write(reserved_write), .op_mode(op_mode),
        .applied_code(applied_code), .applied_mv(applied_mv));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input string what, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic verify_all();
        int m;
        for (int i = 0; i < 4; i++) begin
            m = (i == 3) ? 0 : i;
            host.read(8'(8'h35 + m), int'(rnd() % 3), d);
            check("reg_rdata", 12'({1'b0, rng, code_e[m]}), 12'(d));
            check("reg_hit", 12'h001, 12'(reg_hit));
            op_mode = 2'(i);
            repeat (2) @(posedge clk);
            #2;
            check("applied_code", 12'({rng, code_e[m]}), 12'(applied_code));
            check("applied_mv", rng ? 12'(800 + 50 * code_e[m]) : 12'(400 + 25 * code_e[m]),
                  applied_mv);
        end
    endtask : verify_all
    task automatic wr_chk(input int m, input logic [7:0] w);
        host.write(8'(8'h35 + m), w, int'(rnd() % 3), f);
        code_e[m] = w[5:0];
        check("reserved_write", 12'(rng && w[5:0] > 6'h32), 12'(f));
        if (!(rng && w[5:0] > 6'h32))
            verify_all();
    endtask : wr_chk
    task automatic do_reset(input logic v, input logic r);
        @(posedge clk);
        #2;
        reset = 1'b1;
        fuse_valid = v;
        fuse_range = r;
        repeat (2) @(posedge clk);
        #2;
        reset = 1'b0;
        rng = v & r;
        code_e = '{default: 6'h00};
        repeat (2) @(posedge clk);
        #2;
        fuse_range = ~r;
        verify_all();
    endtask : do_reset
    task automatic complete_run();
        $display("Checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    initial begin
        #400000;
        err_total++;
        complete_run();
    end
    initial begin
        do_reset(1'b0, 1'b1);
        for (int k = 0; k < 30; k++) wr_chk(int'(rnd() % 3), 8'(rnd() % 55 + 9) | 8'(rnd() & 32'hC0));
        wr_chk(2, 8'h3F);
        do_reset(1'b1, 1'b1);
        for (int k = 0; k < 30; k++) wr_chk(int'(rnd() % 3), 8'(rnd() % 27 + 24) | 8'(rnd() & 32'hC0));
        wr_chk(1, 8'h33);
        wr_chk(1, 8'h32);
        wr_chk(2, 8'hFF);
        wr_chk(2, 8'h58);
        host.write(8'h38, 8'h15, 0, f);
        host.read(8'h38, 0, d);
        check("unmapped reg_rdata", 12'h000, 12'(d));
        check("reg_hit", 12'h000, 12'(reg_hit));
        verify_all();
        complete_run();
    end
endmodule : buck_setpoint_registers_tb
